// >>> hw/supply_monitor_irq_regs.sv
// Operation
// - after reset control is locked; writes ignored until key written
// - key to lock register unlocks; any other value relocks
// - unlocked control stays writable for any number of writes
// - lock register reads one when locked, zero when unlocked
// - control bit 7 is enable, reset 0; clear stops detector
// - with enable clear the cause flag is never set
// - level field bits 5:2, reset 0000; software avoids illegal codes
// - control bits 1:0 read zero, writes ignored
// - cause bit 7 shows detected event; other bits zero
// - writing 0 to clear bit 7 clears flag; 1 does nothing
// - clear register reads bit 7 one, others zero
// - ready bit 7 is 1 only while monitoring active
// - deep-standby reset does not reinitialize registers
// - after enable and level set, wait stabilization, then ready
// - supply below level while active sets flag and request
// - clear write drops flag and request even if still low
`timescale 1ns/1ps
`include "supply_monitor_params.svh"
module supply_monitor_irq_regs
#(
  parameter int unsigned STAB_CYCLES = `STAB_CYCLES_DEFAULT
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire supply_monitor_pkg::addr_t paddr,
  input wire supply_monitor_pkg::word_t pwdata,
  output logic pready,
  output logic pslverr,
  output supply_monitor_pkg::word_t prdata,
  // analog detector side
  input wire logic below_level_async,
  input wire logic stab_done_async,
  output logic detector_run,
  output logic [3:0] detector_level,
  output logic detector_restart,
  // deep standby reset (no effect on registers)
  input wire logic deep_standby_rst,
  // interrupt request
  output logic supply_irq
);
  import supply_monitor_pkg::*;

  logic locked_reg;
  logic enable_reg;
  logic [3:0] level_reg;
  logic cause_reg;
  mon_state_e state_reg;
  logic [15:0] stab_cnt_reg;
  logic below_sync;
  logic stab_sync;
  logic wr_acc;
  logic rd_acc;
  logic ctl_wr;
  logic clr_wr;
  logic lock_wr;
  logic ctl_change;
  logic mapped;
  logic clear_req;
  logic set_req;
  logic deep_unused;

  function automatic logic hit(input addr_t a, input addr_t ofs);
    return a == ofs;
  endfunction

  // one-cycle access; writes take effect at the access edge, read data is captured at the setup edge
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !pwrite;
  assign mapped = hit(paddr, `OFS_CONTROL) || hit(paddr, `OFS_CAUSE) ||
    hit(paddr, `OFS_CAUSE_CLEAR) || hit(paddr, `OFS_LOCK) ||
    hit(paddr, `OFS_READY);
  assign pslverr = psel && penable && !mapped;
  assign ctl_wr = wr_acc && hit(paddr, `OFS_CONTROL) && !locked_reg;
  assign lock_wr = wr_acc && hit(paddr, `OFS_LOCK);
  assign clr_wr = wr_acc && hit(paddr, `OFS_CAUSE_CLEAR);
  assign clear_req = clr_wr && !pwdata[`CLEAR_BIT];
  assign deep_unused = deep_standby_rst;
  assign ctl_change = ctl_wr &&
    (pwdata[`CTL_ENABLE_BIT] != enable_reg ||
     pwdata[`CTL_LEVEL_HI:`CTL_LEVEL_LO] != level_reg);

  level_sync u_below_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(below_level_async),
    .sync_out(below_sync)
  );

  level_sync u_stab_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(stab_done_async),
    .sync_out(stab_sync)
  );

  // lock state: only presetn resets it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      locked_reg <= 1'b1;
    else if (lock_wr)
      locked_reg <= (pwdata != `LOCK_KEY);
  end

  // control fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_reg <= `CTL_ENABLE_RESET;
      level_reg <= `CTL_LEVEL_RESET;
    end
    else if (ctl_wr)
    begin
      enable_reg <= pwdata[`CTL_ENABLE_BIT];
      level_reg <= pwdata[`CTL_LEVEL_HI:`CTL_LEVEL_LO];
    end
  end

  // monitor sequencing: stopped, settling, active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= mon_stopped;
      stab_cnt_reg <= '0;
    end
    else if (!enable_reg)
    begin
      state_reg <= mon_stopped;
      stab_cnt_reg <= '0;
    end
    else if (ctl_change)
    begin
      // a disabling write stops at once so ready never outlives the enable
      if (pwdata[`CTL_ENABLE_BIT])
        state_reg <= mon_settling;
      else
        state_reg <= mon_stopped;
      stab_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        mon_stopped:
        begin
          state_reg <= mon_settling;
          stab_cnt_reg <= '0;
        end
        mon_settling:
        begin
          if (stab_sync && stab_cnt_reg >= 16'(STAB_CYCLES - 1))
            state_reg <= mon_active;
          else if (stab_cnt_reg < 16'(STAB_CYCLES - 1))
            stab_cnt_reg <= stab_cnt_reg + 16'd1;
        end
        mon_active:
          state_reg <= mon_active;
      endcase
    end
  end

  assign set_req = (state_reg == mon_active) && enable_reg && below_sync;

  // cause flag: clear write wins over a still-low supply
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_reg <= 1'b0;
    else if (clear_req)
      cause_reg <= 1'b0;
    else if (set_req)
      cause_reg <= 1'b1;
  end

  // read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_acc && !penable)
    begin
      prdata <= '0;
      if (hit(paddr, `OFS_CONTROL))
      begin
        prdata[`CTL_ENABLE_BIT] <= enable_reg;
        prdata[`CTL_RSVD_ONE_BIT] <= 1'b1;
        prdata[`CTL_LEVEL_HI:`CTL_LEVEL_LO] <= level_reg;
      end
      else if (hit(paddr, `OFS_CAUSE))
        prdata[`CAUSE_FLAG_BIT] <= cause_reg;
      else if (hit(paddr, `OFS_CAUSE_CLEAR))
        prdata[`CLEAR_BIT] <= 1'b1;
      else if (hit(paddr, `OFS_LOCK))
        prdata <= locked_reg ? `LOCK_READ_LOCKED : `LOCK_READ_OPEN;
      else if (hit(paddr, `OFS_READY))
        prdata[`READY_FLAG_BIT] <= (state_reg == mon_active);
    end
  end

  // outputs to the detector and interrupt controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detector_run <= 1'b0;
      detector_level <= `CTL_LEVEL_RESET;
      detector_restart <= 1'b0;
      supply_irq <= 1'b0;
    end
    else
    begin
      detector_run <= enable_reg;
      detector_level <= level_reg;
      detector_restart <= ctl_change;
      supply_irq <= clear_req ? 1'b0 : (cause_reg || set_req);
    end
  end

  a_locked_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && hit(paddr, `OFS_CONTROL) && locked_reg
    |=> $stable(enable_reg) && $stable(level_reg))
    else $error("control changed while locked");
  a_stay_locked: assert property (
    @(posedge pclk) disable iff (!presetn)
    locked_reg && !lock_wr |=> locked_reg)
    else $error("control unlocked without lock write");
  a_key_unlock: assert property (
    @(posedge pclk) disable iff (!presetn)
    lock_wr |=> locked_reg == ($past(pwdata) != `LOCK_KEY))
    else $error("lock state wrong after lock write");
  a_stay_open: assert property (
    @(posedge pclk) disable iff (!presetn)
    !locked_reg && !lock_wr |=> !locked_reg)
    else $error("control relocked without lock write");
  a_ctl_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && hit(paddr, `OFS_CONTROL) && !locked_reg
    |=> enable_reg == $past(pwdata[`CTL_ENABLE_BIT])
    && level_reg == $past(pwdata[`CTL_LEVEL_HI:`CTL_LEVEL_LO]))
    else $error("unlocked control write lost");
  a_lock_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !penable && hit(paddr, `OFS_LOCK)
    |=> prdata == word_t'(locked_reg))
    else $error("lock read value wrong");
  a_run_stops: assert property (
    @(posedge pclk) disable iff (!presetn)
    !enable_reg |=> !detector_run)
    else $error("detector running while disabled");
  a_stop_now: assert property (
    @(posedge pclk) disable iff (!presetn)
    !enable_reg |=> state_reg == mon_stopped)
    else $error("monitor not stopped while disabled");
  a_no_cause_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !enable_reg && !cause_reg |=> !cause_reg)
    else $error("cause set while disabled");
  a_ctl_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !penable && hit(paddr, `OFS_CONTROL)
    |=> prdata[`CTL_LEVEL_LO-1:0] == '0 && prdata[`CTL_RSVD_ONE_BIT]
    && prdata[`CTL_ENABLE_BIT] == $past(enable_reg))
    else $error("control read value wrong");
  a_cause_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !penable && hit(paddr, `OFS_CAUSE)
    |=> prdata == (word_t'($past(cause_reg)) << `CAUSE_FLAG_BIT))
    else $error("cause read value wrong");
  a_write_one_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    clr_wr && pwdata[`CLEAR_BIT] && !set_req |=> $stable(cause_reg))
    else $error("writing one changed the cause flag");
  a_clear_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !penable && hit(paddr, `OFS_CAUSE_CLEAR)
    |=> prdata == (word_t'(1'b1) << `CLEAR_BIT))
    else $error("clear register read value wrong");
  a_ready_needs_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == mon_active |-> enable_reg)
    else $error("active while disabled");
  a_ready_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_acc && !penable && hit(paddr, `OFS_READY)
    |=> prdata == (word_t'($past(state_reg) == mon_active)
    << `READY_FLAG_BIT))
    else $error("ready read value wrong");
  a_deep_ignored: assert property (
    @(posedge pclk) disable iff (!presetn)
    deep_unused && !wr_acc
    |=> $stable(locked_reg) && $stable(enable_reg)
    && $stable(level_reg))
    else $error("registers changed by deep standby reset");
  a_settle_time: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg == mon_settling) |-> ##1
    (state_reg != mon_active)[*2])
    else $error("ready raised before stabilization");
  a_settle_min: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg == mon_active)
    |-> $past(stab_cnt_reg) >= 16'(STAB_CYCLES - 1))
    else $error("settling cut short");
  a_cause_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_req && !clear_req |=> cause_reg && supply_irq)
    else $error("cause not set on low supply");
  a_irq_matches: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> supply_irq == cause_reg)
    else $error("interrupt request differs from cause flag");
  a_clear_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_req |=> !cause_reg && !supply_irq)
    else $error("clear write did not drop flag");
  a_below_sync: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_req |-> $past(below_level_async, `SYNC_DEPTH))
    else $error("low supply used before synchronisation");
  a_stab_sync: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(state_reg == mon_active)
    |-> $past(stab_done_async, `STAB_SEEN_DEPTH))
    else $error("ready without synchronised stabilization");

  c_unlock: cover property (@(posedge pclk) disable iff (!presetn)
    lock_wr && pwdata == `LOCK_KEY);
  c_active: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(state_reg == mon_active));
  c_cause: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(cause_reg));
  c_clear_low: cover property (@(posedge pclk) disable iff (!presetn)
    clear_req && below_sync && cause_reg);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(state_reg == mon_active));
endmodule

// >>> hw/supply_monitor_params.svh
`ifndef SUPPLY_MONITOR_PARAMS_SVH
`define SUPPLY_MONITOR_PARAMS_SVH

// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_CAUSE 12'h004
`define OFS_CAUSE_CLEAR 12'h008
`define OFS_LOCK 12'h00C
`define OFS_READY 12'h010

// control field layout
`define CTL_ENABLE_BIT 7
`define CTL_RSVD_ONE_BIT 6
`define CTL_LEVEL_HI 5
`define CTL_LEVEL_LO 2
`define CTL_ENABLE_RESET 1'b0
`define CTL_LEVEL_RESET 4'h0
`define CTL_LEVEL_MAX 4'h9
`define CTL_LEVEL_BAD0 4'h5
`define CTL_LEVEL_BAD1 4'h6

// flag bit positions
`define CAUSE_FLAG_BIT 7
`define CLEAR_BIT 7
`define READY_FLAG_BIT 7

// lock values
`define LOCK_KEY 32'h1ACC_E553
`define LOCK_READ_LOCKED 32'h0000_0001
`define LOCK_READ_OPEN 32'h0000_0000

// synchroniser depth, and that depth plus the settling-state update
`define SYNC_DEPTH 2
`define STAB_SEEN_DEPTH 3

// detector stabilization wait, in peripheral clock cycles
`define STAB_CYCLES_DEFAULT 16

`endif

// >>> hw/supply_monitor_pkg.sv
package supply_monitor_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] addr_t;
  typedef enum logic [1:0] {
    mon_stopped,
    mon_settling,
    mon_active
  } mon_state_e;
endpackage

// >>> hw/level_sync.sv
`timescale 1ns/1ps
module level_sync
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// >>> test/supply_monitor_irq_regs_tb.sv
`timescale 1ns/1ps
`include "supply_monitor_params.svh"
module supply_monitor_irq_regs_tb;
  import supply_monitor_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  addr_t paddr = '0;
  word_t pwdata = '0;
  logic pready;
  logic pslverr;
  word_t prdata;
  logic below_level = 0;
  logic stab_done = 0;
  logic deep_rst = 0;
  logic run;
  logic [3:0] level;
  logic irq;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h878e;
  int en_m = 0;
  int lvl_m = 0;
  int lock_m = 1;
  int flag_m = 0;
  int n;
  int lv[8] = '{0, 1, 2, 3, 4, 7, 8, 9};
  word_t rd;
  word_t v;
  logic err;

  supply_monitor_irq_regs #(.STAB_CYCLES(8)) dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata),
    .below_level_async(below_level), .stab_done_async(stab_done),
    .detector_run(run), .detector_level(level),
    .detector_restart(), .deep_standby_rst(deep_rst),
    .supply_irq(irq)
  );

  always #2 pclk = ~pclk;

  task give_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      give_verdict;
    end
  end

  task chk(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task xfer(input logic wr, input addr_t a, input word_t d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rd_chk(input addr_t a, input word_t exp);
    xfer(0, a, '0);
    chk(rd, exp);
  endtask

  task wctl(input word_t d);
    xfer(1, `OFS_CONTROL, d);
    if (lock_m == 0)
    begin
      en_m = d[7];
      lvl_m = d[5:2];
    end
  endtask

  task wlock(input word_t d);
    xfer(1, `OFS_LOCK, d);
    lock_m = (d !== `LOCK_KEY);
  endtask

  task regs_chk;
    v = {24'h0, en_m[0], 1'b1, lvl_m[3:0], 2'b00};
    rd_chk(`OFS_CONTROL, v);
    rd_chk(`OFS_LOCK, word_t'(lock_m));
    rd_chk(`OFS_CAUSE, word_t'(flag_m << 7));
    rd_chk(`OFS_CAUSE_CLEAR, 32'h0000_0080);
    chk(word_t'(run), word_t'(en_m));
    chk(word_t'(level), word_t'(lvl_m));
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    regs_chk;
    rd_chk(`OFS_READY, 32'h0000_0000);
    wctl(32'h0000_00A7);
    regs_chk;
    wlock(`LOCK_KEY);
    regs_chk;
    repeat (3)
    begin
      n = lv[$unsigned($random(seed)) % 8];
      wctl(32'h0000_0003 | word_t'(n << 2));
      regs_chk;
    end
    v = $random(seed);
    if (v === `LOCK_KEY)
      v = v ^ 32'h0000_0001;
    wlock(v);
    wctl(32'h0000_00E7);
    regs_chk;
    @(posedge pclk);
    stab_done <= 1;
    xfer(1, `OFS_CAUSE_CLEAR, 32'h0000_0000);
    wlock(`LOCK_KEY);
    wctl(32'h0000_009C);
    wlock(32'h0000_0000);
    rd_chk(`OFS_READY, 32'h0000_0000);
    n = 0;
    do
    begin
      xfer(0, `OFS_READY, '0);
      n++;
    end
    while (rd !== 32'h0000_0080 && n < 30);
    chk(rd, 32'h0000_0080);
    @(posedge pclk);
    below_level <= 1;
    repeat (6) @(posedge pclk);
    flag_m = 1;
    chk(word_t'(irq), 32'h0000_0001);
    xfer(1, `OFS_CAUSE_CLEAR, 32'h0000_00FF);
    regs_chk;
    @(posedge pclk);
    deep_rst <= 1;
    repeat (3) @(posedge pclk);
    deep_rst <= 0;
    regs_chk;
    xfer(1, `OFS_CAUSE_CLEAR, 32'h0000_0000);
    @(negedge pclk);
    chk(word_t'(irq), 32'h0000_0000);
    regs_chk;
    below_level <= 0;
    repeat (5) @(posedge pclk);
    xfer(1, `OFS_CAUSE_CLEAR, 32'h0000_0000);
    flag_m = 0;
    regs_chk;
    chk(word_t'(irq), 32'h0000_0000);
    wlock(`LOCK_KEY);
    wctl(32'h0000_001C);
    @(posedge pclk);
    below_level <= 1;
    repeat (6) @(posedge pclk);
    regs_chk;
    chk(word_t'(irq), 32'h0000_0000);
    rd_chk(`OFS_READY, 32'h0000_0000);
    xfer(0, 12'h020, '0);
    chk(rd, 32'h0000_0000);
    chk(word_t'(err), 32'h0000_0001);
    give_verdict;
  end
endmodule
